/* rtl/ieb_pkg.sv */
// shared constants, types and states of the immediate and branch decode block
package ieb_pkg;
  // halfword field positions and the word width
  localparam int HW_I_POS = 10;
  localparam int IMM_ROTATE_FIELD_HI = 14;
  localparam int IMM_ROTATE_FIELD_LO = 12;
  localparam int IMM8_HI = 7;
  localparam int PAYLOAD_TOP = 7;
  localparam int WORD_W = 32;
  // selector bounds and layout of the modified immediate
  localparam logic [3:0] SEL_PLAIN = 4'h0;
  localparam logic [3:0] SEL_MID = 4'h1;
  localparam logic [3:0] SEL_HIGH = 4'h2;
  localparam logic [3:0] SEL_ALL = 4'h3;
  localparam logic [7:0] PAYLOAD_ZERO = 8'h00;
  // register numbers
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;
  // data-processing opcodes, the sp shift limit and the pc read-ahead
  localparam logic [3:0] OP_ADD = 4'h8;
  localparam logic [3:0] OP_SUB = 4'hD;
  localparam logic [3:0] OP_EOR = 4'h4;
  localparam logic [4:0] OP_ADDW = 5'h00;
  localparam logic [4:0] OP_SUBW = 5'h0A;
  localparam logic [4:0] SP_MAX_SHIFT = 5'h03;
  localparam logic [31:0] PC_AHEAD = 32'h00000004;
  // values after reset
  localparam logic RST_EXEC_STATE = 1'b1;
  localparam logic RST_SECURE = 1'b1;
  localparam logic [31:0] RST_BRANCH_PC = 32'h00000000;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_FAULT = 3'b100
  } ieb_state_t;

  typedef enum logic [1:0] {
    BK_NONE = 2'h0,
    BK_WORK = 2'h1,
    BK_STATE = 2'h2,
    BK_DIRECT = 2'h3
  } ieb_brkind_t;

  typedef struct packed {
    logic valid;
    logic [15:0] first;
    logic [15:0] second;
    logic [31:0] pc;
  } ieb_inst_t;

  typedef struct packed {
    logic valid;
    logic [31:0] value;
  } ieb_target_t;

  typedef struct packed {
    logic valid;
    logic is32;
    logic immUsed;
    logic [31:0] imm;
    logic carryWrite;
    logic carry;
    logic undef;
    logic unpred;
    logic hint;
    logic spDeprecated;
    ieb_brkind_t brKind;
    logic brCall;
    logic brKnown;
    logic [31:0] brTarget;
  } ieb_dec_t;
endpackage : ieb_pkg

/* rtl/ieb_imm_expand.sv */
// expansion of the modified immediate constant and its carry-out
`timescale 1ns/1ps
`default_nettype none
module ieb_imm_expand
  import ieb_pkg::*;
(
  input wire logic iBit,
  input wire logic [2:0] rot,
  input wire logic [7:0] payload,
  output logic [31:0] value,
  output logic carryDefined,
  output logic carryOut,
  output logic zeroUnpred
);
  logic [4:0] sel;
  logic [31:0] seed;
  logic [63:0] twice;

  assign sel = {iBit, rot, payload[PAYLOAD_TOP]};
  // top bit forced to one, then a plain rotate right by the selector
  assign seed = {24'h000000, 1'b1, payload[6:0]};
  assign twice = {seed, seed} >> sel;

  always_comb begin
    carryDefined = 1'b0;
    zeroUnpred = 1'b0;
    case (sel[4:1])
      SEL_PLAIN: value = {24'h000000, payload};
      SEL_MID: begin
        value = {8'h00, payload, 8'h00, payload};
        zeroUnpred = (payload == PAYLOAD_ZERO);
      end
      SEL_HIGH: begin
        value = {payload, 8'h00, payload, 8'h00};
        zeroUnpred = (payload == PAYLOAD_ZERO);
      end
      SEL_ALL: begin
        value = {payload, payload, payload, payload};
        zeroUnpred = (payload == PAYLOAD_ZERO);
      end
      default: begin
        value = twice[31:0];
        carryDefined = 1'b1;
      end
    endcase
  end

  assign carryOut = value[WORD_W-1];
endmodule : ieb_imm_expand
`default_nettype wire

/* rtl/ieb_decode.sv */
// decode stage: immediates, branch classes, stack-pointer checks, hints
`timescale 1ns/1ps
`default_nettype none
module ieb_decode
  import ieb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mainExt,
  input wire ieb_inst_t inst,
  input wire ieb_target_t target,
  input wire logic restoreValid,
  input wire logic restoreBit,
  output logic decodeReady,
  output ieb_dec_t dec,
  output logic execStateBit,
  output logic secureState,
  output logic [31:0] branchPc,
  output logic branchPcValid,
  output logic invalidStateFault
);
  ieb_state_t state;
  ieb_state_t next_state;
  ieb_dec_t next_dec;
  ieb_brkind_t pendKind;
  logic pendTable;
  logic [31:0] pendPc;

  logic [15:0] f;
  logic [15:0] s;
  logic is32;
  logic [3:0] dpOp;
  logic [3:0] rn;
  logic [3:0] rd;
  logic [3:0] rm;
  logic addSub;
  logic logicOp;
  logic [31:0] immVal;
  logic immCarryDef;
  logic immCarry;
  logic immZero;
  logic [11:0] imm12;
  logic [4:0] shAmt;

  logic isModImm;
  logic isPlainImm;
  logic isDpReg;
  logic isBx;
  logic branch_to_nonsecure;
  logic bxSbzBad;
  logic isPopPc;
  logic isLdmPc;
  logic isLdrPc;
  logic isCbz;
  logic isBranch;
  logic isCall;
  logic isTbb;
  logic isHint16;
  logic isHint32;
  logic hintSbxBad;
  logic isMovReg;
  logic spBad;
  logic spDep;
  logic [31:0] farOff;
  logic [31:0] cbzOff;
  logic accept;
  logic needWait;

  assign f = inst.first;
  assign s = inst.second;
  assign is32 = (f[15:13] == 3'b111) && (f[12:11] != 2'b00);
  assign dpOp = f[8:5];
  assign rn = f[3:0];
  assign rd = s[11:8];
  assign rm = s[3:0];
  assign addSub = (dpOp == OP_ADD) || (dpOp == OP_SUB);
  assign logicOp = (dpOp[3:2] == 2'b00) || (dpOp == OP_EOR);
  assign imm12 = {f[HW_I_POS], s[IMM_ROTATE_FIELD_HI:IMM_ROTATE_FIELD_LO], s[IMM8_HI:0]};
  assign shAmt = {s[14:12], s[7:6]};

  // expanded for every wide instruction; only the data forms use the result
  ieb_imm_expand u_imm (
    .iBit(f[HW_I_POS]),
    .rot(s[IMM_ROTATE_FIELD_HI:IMM_ROTATE_FIELD_LO]),
    .payload(s[IMM8_HI:0]),
    .value(immVal),
    .carryDefined(immCarryDef),
    .carryOut(immCarry),
    .zeroUnpred(immZero)
  );

  // instruction classes
  assign isModImm = is32 && (f[15:11] == 5'h1E) && !f[9] && !s[15];
  assign isPlainImm = is32 && (f[15:11] == 5'h1E) && f[9] && !s[15]
    && ((f[8:4] == OP_ADDW) || (f[8:4] == OP_SUBW));
  assign isDpReg = is32 && (f[15:9] == 7'b1110101) && !s[15];
  assign isBx = !is32 && (f[15:8] == 8'h47);
  assign branch_to_nonsecure = isBx && (f[2:0] == 3'b100);
  assign bxSbzBad = isBx && (f[2:0] != 3'b000) && !branch_to_nonsecure;
  assign isPopPc = !is32 && (f[15:9] == 7'b1011110) && f[8];
  // second[13] should be zero here but load-multiple keeps going regardless
  assign isLdmPc = is32 && (f[15:9] == 7'b1110100) && (f[8] ^ f[7])
    && !f[6] && f[4] && s[15];
  assign isLdrPc = is32 && (f[15:8] == 8'hF8) && (f[6:4] == 3'b101)
    && (s[15:12] == REG_PC);
  assign isCbz = !is32 && (f[15:12] == 4'hB) && !f[10] && f[8];
  assign isBranch = is32 && (f[15:11] == 5'h1E) && (s[15:14] == 2'b10) && s[12];
  assign isCall = is32 && (f[15:11] == 5'h1E) && (s[15:14] == 2'b11) && s[12];
  assign isTbb = is32 && (f[15:4] == 12'hE8D) && (s[7:4] == 4'h0);
  assign isHint16 = !is32 && (f[15:8] == 8'hBF) && (f[3:0] == 4'h0);
  assign isHint32 = is32 && (f[15:4] == 12'hF3A) && (s[15:14] == 2'b10) && !s[12]
    && (s[10:8] == 3'b000);
  // wrong should-be bits undefine a wide hint rather than guess at its meaning
  assign hintSbxBad = isHint32 && ((f[3:0] != 4'hF) || s[13] || s[11]);
  // plain register moves to or from sp carry no shift and set no flags
  assign isMovReg = isDpReg && (dpOp == 4'h2) && (rn == REG_PC) && !f[4]
    && (shAmt == 5'h00) && (s[5:4] == 2'b00);

  // far reach offset: S, I1, I2, imm10, imm11, 0 sign-extended
  assign farOff = {{7{f[10]}}, f[10], ~(s[13] ^ f[10]), ~(s[11] ^ f[10]),
    f[9:0], s[10:0], 1'b0};
  // compare-branch reaches forward only, 0 to 126
  assign cbzOff = {25'h0000000, f[9], f[7:3], 1'b0};

  // stack pointer checks
  always_comb begin
    spBad = 1'b0;
    if (isModImm) begin
      if (rd == REG_SP && !(addSub && rn == REG_SP && immVal[1:0] == 2'b00)) begin
        spBad = 1'b1;
      end
      if (rn == REG_SP && !addSub) begin
        spBad = 1'b1;
      end
    end
    if (isPlainImm && rd == REG_SP && !(rn == REG_SP && imm12[1:0] == 2'b00)) begin
      spBad = 1'b1;
    end
    if (isDpReg && !isMovReg) begin
      if (rd == REG_SP && !(addSub && rn == REG_SP && s[5:4] == 2'b00
          && shAmt <= SP_MAX_SHIFT)) begin
        spBad = 1'b1;
      end
      if (rm == REG_SP || (rn == REG_SP && !addSub)) begin
        spBad = 1'b1;
      end
    end
  end

  // deprecated only: flagged for software, still executed
  assign spDep = !is32 && ((f[15:8] == 8'h44) || (f[15:8] == 8'h45))
    && (f[6:3] == REG_SP);

  always_comb begin
    next_dec = '0;
    next_dec.valid = accept && execStateBit;
    next_dec.is32 = is32;
    next_dec.imm = isPlainImm ? {20'h00000, imm12} : immVal;
    next_dec.immUsed = isModImm || isPlainImm;
    // carry only moves for flag-setting logical ops on shifted constants
    next_dec.carryWrite = isModImm && f[4] && logicOp && immCarryDef;
    next_dec.carry = immCarry;
    next_dec.unpred = (isModImm && immZero) || spBad;
    next_dec.undef = spBad || bxSbzBad || hintSbxBad;
    next_dec.hint = isHint16 || (isHint32 && mainExt && !hintSbxBad);
    if (isHint32 && !mainExt) begin
      next_dec.undef = 1'b1;
    end
    next_dec.spDeprecated = spDep;
    next_dec.brKind = BK_NONE;
    if (isBx && !branch_to_nonsecure) begin
      next_dec.brKind = BK_WORK;
      next_dec.brCall = f[7];
    end
    if (isPopPc || isLdmPc || isLdrPc) begin
      next_dec.brKind = BK_WORK;
    end
    if (branch_to_nonsecure) begin
      next_dec.brCall = f[7];
      if (secureState) begin
        next_dec.brKind = BK_STATE;
      end else begin
        next_dec.undef = 1'b1;
      end
    end
    if (isBranch || isCall) begin
      next_dec.brKind = BK_DIRECT;
      next_dec.brCall = isCall;
      next_dec.brKnown = 1'b1;
      next_dec.brTarget = inst.pc + PC_AHEAD + farOff;
    end
    if (isCbz) begin
      next_dec.brKind = BK_DIRECT;
      next_dec.brKnown = 1'b1;
      next_dec.brTarget = inst.pc + PC_AHEAD + cbzOff;
    end
    if (isTbb) begin
      next_dec.brKind = BK_DIRECT; // table entry comes back from execute
    end
  end

  // nothing is taken while a branch waits or a fault is being reported
  assign accept = inst.valid && (state == ST_RUN);
  assign needWait = (next_dec.brKind != BK_NONE) && !next_dec.brKnown
    && !next_dec.undef;

  // one-hot states; a fault returns to run on the next edge by itself
  always_comb begin
    case (state)
      ST_RUN: begin
        if (accept && !execStateBit) begin
          next_state = ST_FAULT;
        end else if (accept && needWait) begin
          next_state = ST_WAIT;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_WAIT: next_state = target.valid ? ST_RUN : ST_WAIT;
      ST_FAULT: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // the fault state lasts one cycle; the state bit keeps it coming back
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ready follows the next state so fetch holds its offer while a branch waits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      decodeReady <= 1'b1;
    end else begin
      decodeReady <= (next_state == ST_RUN);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      invalidStateFault <= 1'b0;
    end else begin
      invalidStateFault <= (next_state == ST_FAULT);
    end
  end

  // fields hold for execute; only the valid pulse is cleared
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dec <= '0;
    end else if (accept) begin
      dec <= next_dec;
    end else begin
      dec.valid <= 1'b0;
    end
  end

  // what the pending branch needs once execute returns its value
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pendKind <= BK_NONE;
      pendTable <= 1'b0;
      pendPc <= RST_BRANCH_PC;
    end else if (accept && needWait) begin
      pendKind <= next_dec.brKind;
      pendTable <= isTbb;
      pendPc <= inst.pc;
    end
  end

  // valid pulses once for each landing address
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      branchPcValid <= 1'b0;
    end else begin
      branchPcValid <= (state == ST_WAIT) && target.valid;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      branchPc <= RST_BRANCH_PC;
    end else begin
      if (state == ST_WAIT && target.valid) begin
        if (pendTable) begin
          // byte table: twice the entry, 0 to 510 past pc + 4
          branchPc <= pendPc + PC_AHEAD + {23'h000000, target.value[7:0], 1'b0};
        end else begin
          branchPc <= {target.value[31:1], 1'b0};
        end
      end
    end
  end

  // restore from exception entry outranks a branch landing in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      execStateBit <= RST_EXEC_STATE;
    end else if (restoreValid) begin
      execStateBit <= restoreBit;
    end else if (state == ST_WAIT && target.valid && pendKind == BK_WORK) begin
      execStateBit <= target.value[0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      secureState <= RST_SECURE;
    end else if (state == ST_WAIT && target.valid && pendKind == BK_STATE) begin
      secureState <= target.value[0];
    end
  end
endmodule : ieb_decode
`default_nettype wire

/* verif/ieb_decode_props.sv */
// assertions on the decode stage ports
`timescale 1ns/1ps
`default_nettype none
module ieb_decode_props
  import ieb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mainExt,
  input wire ieb_inst_t inst,
  input wire ieb_target_t target,
  input wire logic restoreValid,
  input wire logic restoreBit,
  input wire logic decodeReady,
  input wire ieb_dec_t dec,
  input wire logic execStateBit,
  input wire logic secureState,
  input wire logic [31:0] branchPc,
  input wire logic branchPcValid,
  input wire logic invalidStateFault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    inst.valid && decodeReady;
  endsequence
  // the fault cycle also drops ready, so it is kept out of the resolve window
  sequence s_resolve;
    !decodeReady && target.valid && !invalidStateFault;
  endsequence
  property p_decode; s_take ##0 execStateBit |=> dec.valid; endproperty
  a_decode: assert property (p_decode) else $error("no decode after take");
  property p_fault; s_take ##0 !execStateBit |=> invalidStateFault && !dec.valid; endproperty
  a_fault: assert property (p_fault) else $error("no invalid state fault");
  property p_work;
    s_resolve ##0 (dec.brKind == BK_WORK && !restoreValid) |=>
      execStateBit == $past(target.value[0]);
  endproperty
  a_work: assert property (p_work) else $error("state bit not from target");
  property p_state;
    s_resolve ##0 dec.brKind == BK_STATE |=> secureState == $past(target.value[0]);
  endproperty
  a_state: assert property (p_state) else $error("security state wrong");
  property p_resolve; s_resolve |=> branchPcValid && decodeReady && !branchPc[0]; endproperty
  a_resolve: assert property (p_resolve) else $error("branch not resolved");
  property p_wait;
    dec.valid && !dec.undef && dec.brKind != BK_NONE && !dec.brKnown |-> !decodeReady;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait for target");
  property p_noWait;
    dec.valid && (dec.undef || (dec.brKind == BK_DIRECT && dec.brKnown)) |-> decodeReady;
  endproperty
  a_noWait: assert property (p_noWait) else $error("undefined or direct waits");
  property p_carry;
    dec.valid && dec.carryWrite |-> dec.immUsed && dec.is32 && dec.carry == dec.imm[31];
  endproperty
  a_carry: assert property (p_carry) else $error("carry not constant top bit");
  property p_hint; dec.valid && dec.is32 && dec.hint |-> $past(mainExt); endproperty
  a_hint: assert property (p_hint) else $error("wide hint without extension");
endmodule : ieb_decode_props
bind ieb_decode ieb_decode_props u_props (
  .core_clk(core_clk), .resetn(resetn), .mainExt(mainExt), .inst(inst), .target(target),
  .restoreValid(restoreValid), .restoreBit(restoreBit), .decodeReady(decodeReady), .dec(dec),
  .execStateBit(execStateBit), .secureState(secureState), .branchPc(branchPc),
  .branchPcValid(branchPcValid), .invalidStateFault(invalidStateFault)
);
`default_nettype wire

/* verif/tb_imm_expand_branch_decode.sv */
// self-checking bench for the decode stage
`timescale 1ns/1ps
`default_nettype none
module tb_imm_expand_branch_decode
  import ieb_pkg::*;
;
  logic core_clk, resetn, mainExt, restoreValid, restoreBit;
  ieb_inst_t inst;
  ieb_target_t target;
  logic decodeReady, execStateBit, secureState, branchPcValid, invalidStateFault;
  ieb_dec_t dec;
  logic [31:0] branchPc;
  int failures = 0;
  int n_compared = 0;
  ieb_decode dut (.core_clk(core_clk), .resetn(resetn), .mainExt(mainExt), .inst(inst),
    .target(target), .restoreValid(restoreValid), .restoreBit(restoreBit),
    .decodeReady(decodeReady), .dec(dec), .execStateBit(execStateBit),
    .secureState(secureState), .branchPc(branchPc), .branchPcValid(branchPcValid),
    .invalidStateFault(invalidStateFault));
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  // offers one instruction; returns in the cycle after the taking edge
  task automatic send(input logic [15:0] f, input logic [15:0] s, input logic [31:0] p);
    int k;
    k = 0;
    // one idle edge between offers so valid never falls and rises in one step
    @(posedge core_clk);
    #1;
    while (decodeReady !== 1'h1 && k < 50) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k == 50) begin
      failures++;
      close_out();
    end
    inst = '{1'h1, f, s, p};
    @(posedge core_clk);
    #1;
    inst.valid = 1'h0;
  endtask : send
  // one target pulse while the branch waits
  task automatic resolve(input logic [31:0] v);
    target = '{1'h1, v};
    @(posedge core_clk);
    #1;
    target.valid = 1'h0;
    chk1(branchPcValid, 1'h1);
    chk32(branchPc, {v[31:1], 1'h0});
  endtask : resolve
  function automatic logic [31:0] expand(input logic [4:0] sel, input logic [7:0] b);
    logic [31:0] x;
    x = {24'h0, 1'h1, b[6:0]};
    case (sel[4:1])
      4'h0: return {24'h0, b};
      4'h1: return {8'h0, b, 8'h0, b};
      4'h2: return {b, 8'h0, b, 8'h0};
      4'h3: return {4{b}};
      default: return (x >> sel) | (x << (6'h20 - 6'(sel)));
    endcase
  endfunction : expand
  // flag-setting exclusive-or so the carry of the shifted forms is written
  task automatic t_imm();
    logic [4:0] sel;
    logic [7:0] b;
    logic [31:0] e;
    for (int z = 0; z < 2; z++) begin
      for (int n = 0; n < 32; n++) begin
        sel = 5'(n);
        b = {sel[0], (z == 0) ? 7'h35 : 7'h00};
        e = expand(sel, b);
        send(16'hF091 | {5'h0, sel[4], 10'h0}, {1'h0, sel[3:1], 4'h2, b}, 32'h0);
        chk32(dec.imm, e);
        chk1(dec.carryWrite, sel[4:1] > 4'h3);
        chk1(dec.carry | ~dec.carryWrite, e[31] | ~dec.carryWrite);
        chk1(dec.unpred, b == 8'h00 && sel[4:1] != 4'h0 && sel[4:1] < 4'h4);
      end
    end
  endtask : t_imm
  task automatic t_direct();
    send(16'hB3F8, 16'h0, 32'h100);
    chk32({30'h0, dec.brKind}, {30'h0, BK_DIRECT});
    chk32(dec.brTarget, 32'h182);
    send(16'hF7FF, 16'hBFFE, 32'h00001000);
    chk32(dec.brTarget, 32'h00001000);
    chk1(dec.brCall, 1'h0);
    send(16'hF3FF, 16'hFFFF, 32'h00001000);
    chk32(dec.brTarget, 32'h00401002);
    chk1(dec.brCall & decodeReady, 1'h1);
    // byte table: execute returns the entry, landing is twice it past pc + 4
    send(16'hE8DF, 16'hF001, 32'h00000300);
    chk1(decodeReady, 1'h0);
    target = '{1'h1, 32'h000000FF};
    @(posedge core_clk);
    #1;
    target.valid = 1'h0;
    chk1(branchPcValid, 1'h1);
    chk32(branchPc, 32'h00000502);
  endtask : t_direct
  task automatic t_hint_sp();
    send(16'hBF00, 16'h0, 32'h0);
    chk1(dec.hint, 1'h1);
    send(16'hF3AF, 16'h8000, 32'h0);
    chk1(dec.hint & ~dec.undef, 1'h1);
    mainExt = 1'h0;
    send(16'hF3AF, 16'h8000, 32'h0);
    chk1(dec.undef & ~dec.hint, 1'h1);
    mainExt = 1'h1;
    send(16'hF20D, 16'h0D04, 32'h0);
    chk1(dec.undef, 1'h0);
    send(16'hF20D, 16'h0D06, 32'h0);
    chk1(dec.undef & dec.unpred, 1'h1);
    send(16'hEA4F, 16'h0D01, 32'h0);
    chk1(dec.undef, 1'h0);
    send(16'hEA4F, 16'h010D, 32'h0);
    chk1(dec.undef, 1'h0);
    send(16'hEA41, 16'h010D, 32'h0);
    chk1(dec.undef, 1'h1);
    send(16'hF3A0, 16'h8000, 32'h0);
    chk1(dec.undef & ~dec.hint, 1'h1);
    send(16'h4469, 16'h0, 32'h0);
    chk1(dec.spDeprecated, 1'h1);
    send(16'h4709, 16'h0, 32'h0);
    chk1(dec.undef, 1'h1);
  endtask : t_hint_sp
  // register exchange, wide load to pc, pop of pc; then a clear state bit
  task automatic t_work();
    logic [15:0] f[3] = '{16'h4708, 16'hF8D1, 16'hBD00};
    logic [15:0] s[3] = '{16'h0, 16'hF000, 16'h0};
    for (int n = 0; n < 3; n++) begin
      send(f[n], s[n], 32'h200);
      chk32({30'h0, dec.brKind}, {30'h0, BK_WORK});
      chk1(decodeReady, 1'h0);
      resolve(32'h2001 + 32'(n * 16));
      chk1(execStateBit, 1'h1);
    end
    send(16'h4708, 16'h0, 32'h200);
    resolve(32'h3000);
    chk1(execStateBit, 1'h0);
    send(16'hBF00, 16'h0, 32'h0);
    chk1(invalidStateFault & ~dec.valid, 1'h1);
    restoreBit = 1'h1;
    restoreValid = 1'h1;
    @(posedge core_clk);
    #1;
    restoreValid = 1'h0;
    chk1(execStateBit, 1'h1);
  endtask : t_work
  task automatic t_state();
    send(16'h470C, 16'h0, 32'h0);
    chk32({30'h0, dec.brKind}, {30'h0, BK_STATE});
    resolve(32'h4000);
    chk1(secureState, 1'h0);
    send(16'h470C, 16'h0, 32'h0);
    chk1(dec.undef & decodeReady, 1'h1);
  endtask : t_state
  initial begin
    resetn = 1'h0;
    mainExt = 1'h1;
    restoreValid = 1'h0;
    restoreBit = 1'h0;
    inst = '0;
    target = '0;
    repeat (20) @(posedge core_clk);
    #1;
    resetn = 1'h1;
    chk1(execStateBit & secureState & decodeReady, 1'h1);
    t_imm();
    t_direct();
    t_hint_sp();
    t_work();
    t_state();
    close_out();
  end
endmodule : tb_imm_expand_branch_decode
`default_nettype wire
